// ### odec_defs.svh
// Behaviour
// - Sync timing: enable follows divider clock tick.
// - Async timing: enable changes apply immediately.
// - Group codes 0-4 join groups; 5 none.
// - Code 7 ignores lock, register, pin enables.
// - Code 7 still obeys per-driver disable.
// - Disabled state field sets held pin levels.
// - Low/low becomes high/low in LVDS type.
// - Disable bit stops the clock; pins take the disabled state levels.
// - Clear disable enables unless otherwise gated.
// - Type field: current-mode, LVDS, LVDS, CMOS.
// - Bit 15 inverts differential polarity only.
// - CMOS: bits 9/8 invert true/complement.
// - CMOS: bits 11/10 tristate true/complement.
// - Input function 0-4 drives group enable.
// - Input function 6 drives global enable.
// - Power-down bit switches the driver off.
`ifndef ODEC_DEFS_SVH
`define ODEC_DEFS_SVH

// Register indices on the register port
`define ODEC_IDX_ENABLE 2'h0
`define ODEC_IDX_DRIVER 2'h1
`define ODEC_IDX_STATUS 2'h2

// Reset values and writable masks
`define ODEC_ENABLE_RESET 8'h06
`define ODEC_DRIVER_RESET 16'h003C
`define ODEC_DRIVER_WMASK 16'hFF7F

// Driver type encodings
`define ODEC_MODE_LPCM 2'h0
`define ODEC_MODE_LVDS_A 2'h1
`define ODEC_MODE_LVDS_B 2'h2
`define ODEC_MODE_CMOS 2'h3

// Group field encodings
`define ODEC_GROUP_LAST 3'h4
`define ODEC_GROUP_NONE 3'h5
`define ODEC_GROUP_EXCL 3'h7
`define ODEC_NUM_GROUPS 5

// Disabled state encodings
`define ODEC_DIS_HL 2'h0
`define ODEC_DIS_LH 2'h1
`define ODEC_DIS_HIZ 2'h2
`define ODEC_DIS_LL 2'h3

// Enable timing encodings
`define ODEC_OE_SYNC 1'h0
`define ODEC_OE_ASYNC 1'h1

// Input pin function codes
`define ODEC_FUNC_WIDTH 7
`define ODEC_FUNC_GOE 7'h06

`endif

// ### odec_pkg.sv
package odec_pkg;

    // Enable configuration register layout
    typedef struct packed {
        logic driver_power_down;
        logic oe_mode;
        logic [2:0] group;
        logic [1:0] dis_state;
        logic dis;
    } odec_enable_cfg_type;

    // Driver configuration register layout
    typedef struct packed {
        logic diff_polarity_invert;
        logic spare_prog;
        logic [1:0] cross_point_tune;
        logic true_output_tristate;
        logic complement_output_tristate;
        logic true_output_invert;
        logic complement_output_invert;
        logic reserved;
        logic lp_amplitude;
        logic lp_slew_rate;
        logic lp_impedance;
        logic [1:0] cmos_slew_rate;
        logic [1:0] driver_type;
    } odec_driver_cfg_type;

    // Driven levels and enables of both output pins
    typedef struct packed {
        logic true_output;
        logic true_oe;
        logic complement_output;
        logic complement_oe;
    } odec_pins_type;

    // Global enable conditions
    typedef struct packed {
        logic goe_bit;
        logic apll_locked;
        logic lock_gate_en;
    } odec_global_type;

    // Analog settings handed to the driver cell
    typedef struct packed {
        logic [1:0] cross_point_tune;
        logic [1:0] impedance_tune;
        logic [1:0] amplitude_tune;
        logic lp_amplitude;
        logic lp_slew_rate;
        logic lp_impedance;
        logic [1:0] cmos_slew_rate;
    } odec_analog_type;

endpackage : odec_pkg

// ### odec_gpi_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "odec_defs.svh"
module odec_gpi_decode #(
    parameter int NUM_GPI = 4
) (
    // Pin levels and their configuration
    input wire logic [NUM_GPI-1:0] gpi_level,
    input wire logic [NUM_GPI-1:0] gpi_pol,
    input wire logic [NUM_GPI*`ODEC_FUNC_WIDTH-1:0] gpi_func,
    // Decoded enables
    output logic [`ODEC_NUM_GROUPS-1:0] group_en,
    output logic goe_pin_en
);
    import odec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Unassigned groups read as enabled; several pins on one group all agree
    always_comb begin
        logic [`ODEC_FUNC_WIDTH-1:0] func;
        logic level;
        func = '0;
        level = 1'b0;
        group_en = '1;
        goe_pin_en = 1'b1;
        for (int i = 0; i < NUM_GPI; i++) begin
            func = gpi_func[i*`ODEC_FUNC_WIDTH +: `ODEC_FUNC_WIDTH];
            level = gpi_level[i] ^ gpi_pol[i];
            for (int g = 0; g < `ODEC_NUM_GROUPS; g++) begin
                if (func == `ODEC_FUNC_WIDTH'(g)) begin
                    group_en[g] = group_en[g] & level;
                end
            end
            if (func == `ODEC_FUNC_GOE) begin
                goe_pin_en = goe_pin_en & level;
            end
        end
    end

endmodule : odec_gpi_decode
`default_nettype wire

// ### odec_output_enable.sv
`timescale 1ns/1ns
`default_nettype none
`include "odec_defs.svh"
module odec_output_enable #(
    parameter int NUM_GPI = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic [1:0] reg_sel,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Divider clock level and its one-cycle tick
    input wire logic div_level,
    input wire logic div_tick,
    // Global and pin enable sources
    input wire odec_pkg::odec_global_type global_in,
    input wire logic [NUM_GPI-1:0] gpi_level,
    input wire logic [NUM_GPI-1:0] gpi_pol,
    input wire logic [NUM_GPI*`ODEC_FUNC_WIDTH-1:0] gpi_func,
    // Output driver
    output odec_pkg::odec_pins_type pins,
    output logic driver_power_down,
    output odec_pkg::odec_analog_type analog_cfg
);
    import odec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Type decode helpers
    function automatic logic is_cmos(input logic [1:0] mode);
        is_cmos = (mode == `ODEC_MODE_CMOS);
    endfunction : is_cmos

    function automatic logic is_lvds(input logic [1:0] mode);
        is_lvds = (mode == `ODEC_MODE_LVDS_A) || (mode == `ODEC_MODE_LVDS_B);
    endfunction : is_lvds

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    odec_enable_cfg_type enable_cfg;
    odec_enable_cfg_type next_enable_cfg;
    odec_driver_cfg_type driver_cfg;
    odec_driver_cfg_type next_driver_cfg;
    logic [15:0] next_reg_rdata;
    logic sync_en;
    logic next_sync_en;
    logic eff_en;
    logic raw_en;
    logic group_ok;
    logic global_ok;
    logic [`ODEC_NUM_GROUPS-1:0] group_en;
    logic goe_pin_en;
    odec_pins_type next_pins;

    ////////////////////////////////////////////////////////////////////////
    // Pin function decode
    odec_gpi_decode #(
        .NUM_GPI(NUM_GPI)
    ) u_gpi_decode (
        .gpi_level(gpi_level),
        .gpi_pol(gpi_pol),
        .gpi_func(gpi_func),
        .group_en(group_en),
        .goe_pin_en(goe_pin_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes; the reserved bit stays zero
    always_comb begin
        next_enable_cfg = enable_cfg;
        next_driver_cfg = driver_cfg;
        if (reg_wr) begin
            case (reg_sel)
                `ODEC_IDX_ENABLE: begin
                    next_enable_cfg = odec_enable_cfg_type'(reg_wdata[7:0]);
                end
                `ODEC_IDX_DRIVER: begin
                    next_driver_cfg = odec_driver_cfg_type'(reg_wdata & `ODEC_DRIVER_WMASK);
                end
                default: begin
                    next_enable_cfg = enable_cfg;
                end
            endcase
        end
    end

    // Register readback, one cycle after the select
    always_comb begin
        case (reg_sel)
            `ODEC_IDX_ENABLE: next_reg_rdata = {8'h00, enable_cfg};
            `ODEC_IDX_DRIVER: next_reg_rdata = driver_cfg;
            `ODEC_IDX_STATUS: next_reg_rdata = {13'h0000, sync_en, raw_en, eff_en};
            default: next_reg_rdata = 16'h0000;
        endcase
    end

    // Configuration storage
    always_ff @(posedge mclk) begin
        if (rst) begin
            enable_cfg <= odec_enable_cfg_type'(`ODEC_ENABLE_RESET);
            driver_cfg <= odec_driver_cfg_type'(`ODEC_DRIVER_RESET);
            reg_rdata <= 16'h0000;
        end else begin
            enable_cfg <= next_enable_cfg;
            driver_cfg <= next_driver_cfg;
            reg_rdata <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable terms
    always_comb begin
        group_ok = 1'b1;
        if (enable_cfg.group <= `ODEC_GROUP_LAST) begin
            group_ok = group_en[enable_cfg.group];
        end
        if (enable_cfg.group == `ODEC_GROUP_EXCL) begin
            global_ok = 1'b1;
        end else begin
            global_ok = global_in.goe_bit & goe_pin_en
                & (global_in.apll_locked | ~global_in.lock_gate_en);
        end
        raw_en = ~enable_cfg.dis & group_ok & global_ok;
    end

    // Synchronous enable follows the divider tick
    always_comb begin
        next_sync_en = sync_en;
        if (div_tick) begin
            next_sync_en = raw_en;
        end
        if (enable_cfg.oe_mode == `ODEC_OE_ASYNC) begin
            eff_en = raw_en;
        end else begin
            eff_en = sync_en;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_en <= 1'b0;
        end else begin
            sync_en <= next_sync_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin levels and enables
    always_comb begin
        next_pins = '0;
        if (enable_cfg.driver_power_down) begin
            next_pins = '0;
        end else if (eff_en) begin
            if (is_cmos(driver_cfg.driver_type)) begin
                next_pins.true_output = div_level ^ driver_cfg.true_output_invert;
                next_pins.complement_output = div_level
                    ^ driver_cfg.complement_output_invert;
                next_pins.true_oe = ~driver_cfg.true_output_tristate;
                next_pins.complement_oe = ~driver_cfg.complement_output_tristate;
            end else begin
                next_pins.true_output = div_level ^ driver_cfg.diff_polarity_invert;
                next_pins.complement_output = ~next_pins.true_output;
                next_pins.true_oe = 1'b1;
                next_pins.complement_oe = 1'b1;
            end
        end else begin
            // Disabled: clock stopped, pins held as configured
            next_pins.true_oe = 1'b1;
            next_pins.complement_oe = 1'b1;
            case (enable_cfg.dis_state)
                `ODEC_DIS_HL: begin
                    next_pins.true_output = 1'b1;
                    next_pins.complement_output = 1'b0;
                end
                `ODEC_DIS_LH: begin
                    next_pins.true_output = 1'b0;
                    next_pins.complement_output = 1'b1;
                end
                `ODEC_DIS_HIZ: begin
                    next_pins.true_oe = 1'b0;
                    next_pins.complement_oe = 1'b0;
                end
                `ODEC_DIS_LL: begin
                    next_pins.true_output = is_lvds(driver_cfg.driver_type);
                    next_pins.complement_output = 1'b0;
                end
                default: begin
                    next_pins = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pins <= '0;
            driver_power_down <= 1'b0;
        end else begin
            pins <= next_pins;
            driver_power_down <= enable_cfg.driver_power_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog settings pass straight from the register
    always_comb begin
        analog_cfg.cross_point_tune = driver_cfg.cross_point_tune;
        analog_cfg.impedance_tune = {driver_cfg.true_output_tristate,
            driver_cfg.complement_output_tristate};
        analog_cfg.amplitude_tune = {driver_cfg.true_output_invert,
            driver_cfg.complement_output_invert};
        analog_cfg.lp_amplitude = driver_cfg.lp_amplitude;
        analog_cfg.lp_slew_rate = driver_cfg.lp_slew_rate;
        analog_cfg.lp_impedance = driver_cfg.lp_impedance;
        analog_cfg.cmos_slew_rate = driver_cfg.cmos_slew_rate;
    end

endmodule : odec_output_enable
`default_nettype wire

// ### odec_output_enable_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "odec_defs.svh"
module odec_output_enable_asserts #(
    parameter int NUM_GPI = 4
) (
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [1:0] reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // Divider and enable sources
    input wire logic div_level,
    input wire logic div_tick,
    input wire odec_pkg::odec_global_type global_in,
    input wire logic [NUM_GPI-1:0] gpi_level,
    input wire logic [NUM_GPI-1:0] gpi_pol,
    input wire logic [NUM_GPI*`ODEC_FUNC_WIDTH-1:0] gpi_func,
    // Driver side
    input wire odec_pkg::odec_pins_type pins,
    input wire logic driver_power_down,
    input wire odec_pkg::odec_analog_type analog_cfg
);
    import odec_pkg::*;
    odec_enable_cfg_type ecfg;
    odec_driver_cfg_type dcfg;
    logic armed;
    logic off_now;
    logic on_now;
    logic cmos_now;
    logic [3:0] held;
    logic [3:0] exp_on;
    logic p15;
    ////////////////////////////////////////////////////////////////
    // Shadow of both configuration registers
    always_ff @(posedge mclk) begin
        armed <= ~rst;
        if (rst) begin
            ecfg <= `ODEC_ENABLE_RESET;
            dcfg <= `ODEC_DRIVER_RESET;
        end else if (reg_wr && reg_sel == `ODEC_IDX_ENABLE) begin
            ecfg <= reg_wdata[7:0];
        end else if (reg_wr && reg_sel == `ODEC_IDX_DRIVER) begin
            dcfg <= reg_wdata & `ODEC_DRIVER_WMASK;
        end
    end
    // Known async states and the pin values they imply
    assign off_now = ecfg.oe_mode & ecfg.dis & ~ecfg.driver_power_down;
    assign on_now = ecfg.oe_mode & ~ecfg.dis & (ecfg.group == 3'h7) & ~ecfg.driver_power_down;
    assign cmos_now = dcfg.driver_type == 2'h3;
    assign p15 = div_level ^ dcfg.diff_polarity_invert;
    assign held = (ecfg.dis_state == 2'h0) ? 4'hD : (ecfg.dis_state == 2'h1) ? 4'h7 :
        (ecfg.dis_state == 2'h2) ? 4'h0 : (dcfg.driver_type[1] ^ dcfg.driver_type[0]) ? 4'hD : 4'h5;
    assign exp_on = cmos_now ? {div_level ^ dcfg.true_output_invert, ~dcfg.true_output_tristate,
        div_level ^ dcfg.complement_output_invert, ~dcfg.complement_output_tristate} :
        {p15, 1'b1, ~p15, 1'b1};
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_pd;
        $past(ecfg.driver_power_down) |-> driver_power_down && pins == 4'h0;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down pins not off");
    property p_analog;
        reg_wr && reg_sel == 2'h1 |=>
            analog_cfg == {$past(reg_wdata[13:8]), $past(reg_wdata[6:2])};
    endproperty
    a_analog: assert property (p_analog) else $error("analog field mismatch");
    property p_rd_en;
        armed && $past(reg_sel) == 2'h0 |-> reg_rdata == {8'h00, $past(ecfg)};
    endproperty
    a_rd_en: assert property (p_rd_en) else $error("enable cfg readback");
    property p_rd_drv;
        armed && $past(reg_sel) == 2'h1 |-> reg_rdata == $past(dcfg);
    endproperty
    a_rd_drv: assert property (p_rd_drv) else $error("driver cfg readback");
    property p_rd_none;
        armed && $past(reg_sel) == 2'h3 |-> reg_rdata == 16'h0000;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
    property p_off;
        armed && $past(off_now) |-> pins == $past(held);
    endproperty
    a_off: assert property (p_off) else $error("disabled levels wrong");
    property p_diff;
        armed && $past(on_now) && !$past(cmos_now) |-> pins == $past(exp_on);
    endproperty
    a_diff: assert property (p_diff) else $error("differential pins wrong");
    property p_cmos;
        armed && $past(on_now) && $past(cmos_now) |-> pins == $past(exp_on);
    endproperty
    a_cmos: assert property (p_cmos) else $error("cmos pins wrong");
    c_off: cover property (off_now);
    c_diff: cover property (on_now && !cmos_now);
    c_cmos: cover property (on_now && cmos_now);
endmodule : odec_output_enable_asserts
bind odec_output_enable odec_output_enable_asserts #(.NUM_GPI(NUM_GPI)) asserts_inst (.mclk,
    .rst, .reg_wr, .reg_sel, .reg_wdata, .reg_rdata, .div_level, .div_tick, .global_in,
    .gpi_level, .gpi_pol, .gpi_func, .pins, .driver_power_down, .analog_cfg);
`default_nettype wire

// ### odec_board_load.sv
`timescale 1ns/1ns
`default_nettype none
module odec_board_load (
    // Clock and driven pins
    input wire logic mclk,
    input wire odec_pkg::odec_pins_type pins,
    // Levels seen by the receiver
    output logic true_wire,
    output logic comp_wire
);
    import odec_pkg::*;
    logic true_last = 1'b0;
    logic comp_last = 1'b0;
    // A released line shows a pattern that changes every cycle
    assign true_wire = pins.true_oe ? pins.true_output : ~true_last;
    assign comp_wire = pins.complement_oe ? pins.complement_output : ~comp_last;
    always @(posedge mclk) begin
        true_last <= true_wire;
        comp_last <= comp_wire;
    end
endmodule : odec_board_load
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import odec_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [1:0] reg_sel = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] rd;
    logic div_level = 1'b0;
    logic div_tick;
    logic tick_req = 1'b0;
    logic run_tick = 1'b0;
    logic div_run = 1'b0;
    logic [2:0] dcnt = 3'h0;
    odec_global_type global_in = 3'h6;
    logic [3:0] gpi_level = 4'h0;
    logic [3:0] gpi_pol = 4'h0;
    logic [27:0] gpi_func = {4{7'h7F}};
    odec_pins_type pins;
    odec_analog_type analog_cfg;
    logic driver_power_down;
    logic true_wire;
    logic comp_wire;
    int n_errors = 0;
    int comparisons = 0;
    odec_output_enable #(.NUM_GPI(4)) odec_output_enable_inst (.mclk, .rst, .reg_wr,
        .reg_sel, .reg_wdata, .reg_rdata, .div_level, .div_tick, .global_in, .gpi_level,
        .gpi_pol, .gpi_func, .pins, .driver_power_down, .analog_cfg);
    odec_board_load odec_board_load_inst (.mclk, .pins, .true_wire, .comp_wire);
    ////////////////////////////////////////////////////////////////
    // Expected raw enable, pin 0 carrying function fn at level lvl
    function automatic logic exp_raw(input logic [7:0] c, input logic [6:0] fn,
        input logic lvl, input odec_global_type g);
        logic goe;
        goe = g.goe_bit && (fn != 7'h06 || lvl) && (g.apll_locked || !g.lock_gate_en);
        exp_raw = !c[0] && (c[5:3] > 3'h4 || fn != c[5:3] || lvl) && (c[5:3] == 3'h7 || goe);
    endfunction : exp_raw
    task automatic wr(input logic [1:0] sel, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_sel <= sel;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_reg(input logic [1:0] sel);
        @(posedge mclk);
        reg_sel <= sel;
        @(posedge mclk);
        #1 rd = reg_rdata;
    endtask : rd_reg
    task automatic tick();
        @(posedge mclk);
        tick_req <= 1'b1;
        @(posedge mclk);
        tick_req <= 1'b0;
    endtask : tick
    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////
    // Clock and divider model, the divider stopped while div_run is low
    initial begin
        forever #20 mclk = ~mclk;
    end
    // Manual ticks while stopped, divider ticks while running
    assign div_tick = div_run ? run_tick : tick_req;
    always @(posedge mclk) begin
        if (div_run) begin
            dcnt <= dcnt + 3'h1;
            div_level <= dcnt[2];
            run_tick <= (dcnt == 3'h7);
        end
    end
    initial begin
        #800000;
        n_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        logic [7:0] c;
        logic [6:0] fn;
        void'($urandom(32'h5107));
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(2'h0);
        `CHK(rd, 16'h0006)
        wr(2'h1, 16'hFFFF);
        rd_reg(2'h1);
        `CHK(rd, 16'hFF7F)
        wr(2'h3, 16'hFFFF);
        rd_reg(2'h3);
        `CHK(rd, 16'h0000)
        wr(2'h1, 16'h0001);
        wr(2'h0, 16'h003D);
        tick();
        @(posedge mclk);
        #1 `CHK(pins, 4'h0)
        wr(2'h0, 16'h003C);
        repeat (3) @(posedge mclk);
        #1 `CHK(pins.true_oe, 1'b0)
        tick();
        #1 `CHK(pins.true_oe, 1'b0)
        @(posedge mclk);
        #1 `CHK(pins, 4'h7)
        `CHK(true_wire ^ comp_wire, 1'b1)
        wr(2'h1, 16'h8001);
        @(posedge mclk);
        #1 `CHK(pins, 4'hD)
        wr(2'h0, 16'h007D);
        @(posedge mclk);
        #1 `CHK(pins, 4'h0)
        wr(2'h0, 16'h00C1);
        @(posedge mclk);
        #1 `CHK({driver_power_down, pins}, 5'h10)
        div_run <= 1'b1;
        for (int i = 0; i < 200; i++) begin
            c = {$urandom_range(7) == 0, 7'($urandom)};
            fn = 7'($urandom_range(6));
            if (fn == 7'h05) fn = 7'h7F;
            @(posedge mclk);
            global_in <= 3'($urandom);
            gpi_level <= 4'($urandom);
            gpi_pol <= 4'($urandom);
            gpi_func <= {{3{7'h7F}}, fn};
            wr(2'h1, 16'($urandom));
            wr(2'h0, {8'h00, c});
            rd_reg(2'h2);
            `CHK(rd[1], exp_raw(c, fn, gpi_level[0] ^ gpi_pol[0], global_in))
            repeat (4) @(posedge mclk);
        end
        close_out();
    end
endmodule : tb_top
`default_nettype wire
